// File: rtl/sios_consts.svh
// Constants of the scale and I/O status register bank.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef SIOS_CONSTS_SVH
`define SIOS_CONSTS_SVH

// Register indices on the register access port
`define SIOS_IDX_SCALE_STATUS 8'h00
`define SIOS_IDX_SCALE_ERROR 8'h01
`define SIOS_IDX_GROSS 8'h02
`define SIOS_IDX_NET 8'h03
`define SIOS_IDX_FLOW 8'h04
`define SIOS_IDX_INPUT_SIGNAL 8'h05
`define SIOS_IDX_AOUT_BASE 8'h06
`define SIOS_IDX_ANALOG_2 8'h07
`define SIOS_IDX_ANALOG_3 8'h08
`define SIOS_IDX_ANALOG_4 8'h09
`define SIOS_IDX_INPUT_11_28 8'h0a
`define SIOS_IDX_INPUT_31_48 8'h0b
`define SIOS_IDX_INPUT_51_68 8'h0c
`define SIOS_IDX_OUTPUT_11_28 8'h0d

// Field positions of the per-scale status register
`define SIOS_BIT_NET_OVF 0
`define SIOS_BIT_GROSS_OVF 1
`define SIOS_BIT_FLOW_OVF 2
`define SIOS_BIT_ZERO_DISP 3
`define SIOS_BIT_ZERO_GROSS 4
`define SIOS_BIT_ZERO_NET 5
`define SIOS_BIT_NET_MODE 6
`define SIOS_BIT_MOTION 7
`define SIOS_BIT_FLOW_DISP 11
`define SIOS_BIT_NET_PREC 12
`define SIOS_BIT_GROSS_PREC 13

// Analog output scaling: raw value in 1e-4 steps, reported in 1e-3 steps
`define SIOS_AOUT_ROUND 17'h00005
`define SIOS_AOUT_DIV 17'h0000a

// Reset values
`define SIOS_RST_WORD 16'h0000
`define SIOS_RST_ERR 8'h00

`endif

// File: rtl/sios_pkg.sv
// Types shared by the scale and I/O status register bank.
// Assumes the constants header sits beside it.
`default_nettype none
`include "sios_consts.svh"
package sios_pkg;
    typedef logic [15:0] sios_word_t;
    typedef logic [16:0] sios_aout_raw_t;
    typedef logic [7:0] sios_idx_t;
endpackage
`default_nettype wire

// File: rtl/sios_status_bank.sv
// Read-only bank of scale status, measured values and digital I/O maps.
// Assumes scale logic on clk_sys; digital input pins are asynchronous.
`default_nettype none
`include "sios_consts.svh"

// Operation
// [RULE1] Status bits 0, 1 and 2 flag net, gross and flow values that overflow one integer register.
// [RULE2] Status bits 3, 4 and 5 flag good zero for displayed, gross and net weight.
// [RULE3] Status bit 6 reads 1 in net mode and 0 in gross mode, and bit 7 flags motion.
// [RULE4] Status bit 11 is set while the display shows flow rate.
// [RULE5] Status bits 12 and 13 flag net and gross weights beyond six digits.
// [RULE6] The master reads weight with status and error code and trusts it only at error zero.
// [RULE7] The master reads flow rate with status and error code and trusts it only at error zero.
// [RULE8] A register presents the load-cell input signal in mV/V.
// [RULE9] Four registers mirror the analog output values rounded to three decimals.
// [RULE10] The first input map holds inputs 11-18 in bits 0-7 and 21-28 in bits 8-15.
// [RULE11] The second input map holds inputs 31-38 in bits 0-7 and 41-48 in bits 8-15.
// [RULE12] The third input map holds inputs 51-58 in bits 0-7 and 61-68 in bits 8-15.
// [RULE13] The output map holds outputs 11-18 in bits 0-7 and 21-28 in bits 8-15.
// [RULE14] The error code register reads zero with no error and holds codes 0 to 255.
// [RULE15] Status bits 8, 9, 10, 14 and 15 always read zero.
// [RULE16] All registers are read-only and writes leave them unchanged.
module sios_status_bank (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic netOvf,
    input wire logic grossOvf,
    input wire logic flowOvf,
    input wire logic zeroDisp,
    input wire logic zeroGross,
    input wire logic zeroNet,
    input wire logic netMode,
    input wire logic motion,
    input wire logic flowDisp,
    input wire logic netPrecLost,
    input wire logic grossPrecLost,
    input wire logic [7:0] errCode,
    input wire sios_pkg::sios_word_t grossWeight,
    input wire sios_pkg::sios_word_t netWeight,
    input wire sios_pkg::sios_word_t flowRate,
    input wire sios_pkg::sios_word_t inputSignal,
    input wire sios_pkg::sios_aout_raw_t aoutRaw0,
    input wire sios_pkg::sios_aout_raw_t aoutRaw1,
    input wire sios_pkg::sios_aout_raw_t aoutRaw2,
    input wire sios_pkg::sios_aout_raw_t aoutRaw3,
    input wire logic [47:0] digInPins,
    input wire sios_pkg::sios_word_t digOutState,
    input wire logic regRd,
    input wire logic regWr,
    input wire sios_pkg::sios_idx_t regIdx,
    input wire sios_pkg::sios_word_t regWdata,
    output logic regAck,
    output logic regErr,
    output sios_pkg::sios_word_t regRdata
);
    sios_pkg::sios_word_t statusQ;
    logic [7:0] errQ;
    sios_pkg::sios_word_t grossQ;
    sios_pkg::sios_word_t netQ;
    sios_pkg::sios_word_t flowQ;
    sios_pkg::sios_word_t sigQ;
    sios_pkg::sios_word_t aoutQ [4];
    sios_pkg::sios_aout_raw_t aoutRaw [4];
    logic [47:0] din1Q;
    logic [47:0] din2Q;
    sios_pkg::sios_word_t inMapQ [3];
    sios_pkg::sios_word_t outMapQ;
    sios_pkg::sios_word_t rdMux;
    logic rdHit;
    logic unusedWdata;

    assign aoutRaw[0] = aoutRaw0;
    assign aoutRaw[1] = aoutRaw1;
    assign aoutRaw[2] = aoutRaw2;
    assign aoutRaw[3] = aoutRaw3;
    // Write data is never stored
    assign unusedWdata = ^regWdata;

    // Per-scale status word, unassigned bits held at zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            statusQ <= `SIOS_RST_WORD;
        end else if (ce) begin
            statusQ <= `SIOS_RST_WORD; // RULE15
            statusQ[`SIOS_BIT_NET_OVF] <= netOvf; // RULE1
            statusQ[`SIOS_BIT_GROSS_OVF] <= grossOvf; // RULE1
            statusQ[`SIOS_BIT_FLOW_OVF] <= flowOvf; // RULE1
            statusQ[`SIOS_BIT_ZERO_DISP] <= zeroDisp; // RULE2
            statusQ[`SIOS_BIT_ZERO_GROSS] <= zeroGross; // RULE2
            statusQ[`SIOS_BIT_ZERO_NET] <= zeroNet; // RULE2
            statusQ[`SIOS_BIT_NET_MODE] <= netMode; // RULE3
            statusQ[`SIOS_BIT_MOTION] <= motion; // RULE3
            statusQ[`SIOS_BIT_FLOW_DISP] <= flowDisp; // RULE4
            statusQ[`SIOS_BIT_NET_PREC] <= netPrecLost; // RULE5
            statusQ[`SIOS_BIT_GROSS_PREC] <= grossPrecLost; // RULE5
        end
    end

    // Measured values, captured in the same cycle as status so they stay coherent
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            errQ <= `SIOS_RST_ERR;
            grossQ <= `SIOS_RST_WORD;
            netQ <= `SIOS_RST_WORD;
            flowQ <= `SIOS_RST_WORD;
            sigQ <= `SIOS_RST_WORD;
        end else if (ce) begin
            errQ <= errCode; // RULE14
            grossQ <= grossWeight; // RULE6
            netQ <= netWeight; // RULE6
            flowQ <= flowRate; // RULE7
            sigQ <= inputSignal; // RULE8
        end
    end

    // Analog mirrors: round half up from 1e-4 to 1e-3 steps
    for (genvar i = 0; i < 4; i++) begin : g_aout
        logic [17:0] roundSum;
        sios_pkg::sios_aout_raw_t rounded;
        // Extra bit keeps a full-scale raw value from wrapping before the divide
        assign roundSum = {1'b0, aoutRaw[i]} + {1'b0, `SIOS_AOUT_ROUND};
        assign rounded = 17'(roundSum / {1'b0, `SIOS_AOUT_DIV});
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                aoutQ[i] <= `SIOS_RST_WORD;
            end else if (ce) begin
                aoutQ[i] <= rounded[15:0]; // RULE9
            end
        end
    end

    // Digital input pins pass two flip-flops before the maps
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            din1Q <= 48'h000000000000;
            din2Q <= 48'h000000000000;
        end else if (ce) begin
            din1Q <= digInPins;
            din2Q <= din1Q;
        end
    end

    // Pin bit 16*k+j maps to map k bit j
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            inMapQ[0] <= `SIOS_RST_WORD;
            inMapQ[1] <= `SIOS_RST_WORD;
            inMapQ[2] <= `SIOS_RST_WORD;
            outMapQ <= `SIOS_RST_WORD;
        end else if (ce) begin
            inMapQ[0] <= din2Q[15:0]; // RULE10
            inMapQ[1] <= din2Q[31:16]; // RULE11
            inMapQ[2] <= din2Q[47:32]; // RULE12
            outMapQ <= digOutState; // RULE13
        end
    end

    // Read decode
    always_comb begin
        rdHit = 1'b1;
        rdMux = `SIOS_RST_WORD;
        case (regIdx)
            `SIOS_IDX_SCALE_STATUS: rdMux = statusQ;
            `SIOS_IDX_SCALE_ERROR: rdMux = {8'h00, errQ}; // RULE14
            `SIOS_IDX_GROSS: rdMux = grossQ;
            `SIOS_IDX_NET: rdMux = netQ;
            `SIOS_IDX_FLOW: rdMux = flowQ;
            `SIOS_IDX_INPUT_SIGNAL: rdMux = sigQ;
            `SIOS_IDX_AOUT_BASE: rdMux = aoutQ[0];
            `SIOS_IDX_ANALOG_2: rdMux = aoutQ[1];
            `SIOS_IDX_ANALOG_3: rdMux = aoutQ[2];
            `SIOS_IDX_ANALOG_4: rdMux = aoutQ[3];
            `SIOS_IDX_INPUT_11_28: rdMux = inMapQ[0];
            `SIOS_IDX_INPUT_31_48: rdMux = inMapQ[1];
            `SIOS_IDX_INPUT_51_68: rdMux = inMapQ[2];
            `SIOS_IDX_OUTPUT_11_28: rdMux = outMapQ;
            default: rdHit = 1'b0;
        endcase
    end

    // Answer one cycle after the request; writes are refused with an error
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            regAck <= 1'b0;
            regErr <= 1'b0;
            regRdata <= `SIOS_RST_WORD;
        end else if (ce) begin
            regAck <= regRd | regWr;
            regErr <= regWr | (regRd & ~rdHit); // RULE16
            regRdata <= (regRd & ~regWr & rdHit) ? rdMux : `SIOS_RST_WORD;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    AST_OVF_FLAGS: assert property (ce |=> // RULE1
        statusQ[2:0] == $past({flowOvf, grossOvf, netOvf}))
        else $error("overflow flags do not follow their sources");
    AST_ZERO_FLAGS: assert property (ce |=> // RULE2
        statusQ[5:3] == $past({zeroNet, zeroGross, zeroDisp}))
        else $error("good zero flags do not follow their sources");
    AST_MODE_MOTION: assert property (ce |=> // RULE3
        statusQ[7:6] == $past({motion, netMode}))
        else $error("net mode or motion bit wrong");
    AST_FLOW_DISP: assert property (ce |=> // RULE4
        statusQ[`SIOS_BIT_FLOW_DISP] == $past(flowDisp))
        else $error("flow display bit wrong");
    AST_PREC: assert property (ce |=> // RULE5
        statusQ[13:12] == $past({grossPrecLost, netPrecLost}))
        else $error("precision flags wrong");
    AST_SIGNAL_READ: assert property (ce && regRd && !regWr && // RULE8
        regIdx == `SIOS_IDX_INPUT_SIGNAL |=> regAck && regRdata == $past(sigQ))
        else $error("input signal read wrong");
    AST_AOUT_ROUND: assert property (ce && aoutRaw0 == 17'h0000e |=> // RULE9
        aoutQ[0] == 16'h0001)
        else $error("analog mirror not rounded");
    AST_AOUT_FULL: assert property (ce && aoutRaw2 == 17'h1ffff |=> // RULE9
        aoutQ[2] == 16'h3333)
        else $error("analog mirror wrapped at full scale");
    sequence sInPin;
        ce && digInPins[0] ##1 ce ##1 ce;
    endsequence
    AST_IN_MAP1: assert property (sInPin and (digInPins[0] [*3]) |=> // RULE10
        inMapQ[0][0])
        else $error("input 11 not mapped to bit 0");
    AST_IN_MAP2: assert property (ce |=> inMapQ[1] == $past(din2Q[31:16])) // RULE11
        else $error("second input map wrong");
    AST_IN_MAP3: assert property (ce |=> inMapQ[2] == $past(din2Q[47:32])) // RULE12
        else $error("third input map wrong");
    AST_OUT_MAP: assert property (ce |=> outMapQ == $past(digOutState)) // RULE13
        else $error("output map wrong");
    AST_ERR_READ: assert property (ce && regRd && !regWr && // RULE14
        regIdx == `SIOS_IDX_SCALE_ERROR |=> regRdata[15:8] == 8'h00 &&
        regRdata[7:0] == $past(errQ))
        else $error("error code read wrong");
    AST_RESERVED: assert property (statusQ[10:8] == 3'h0 && // RULE15
        statusQ[15:14] == 2'h0)
        else $error("unassigned status bit set");
    sequence sWrite;
        ce && regWr;
    endsequence
    AST_WRITE_REFUSED: assert property (sWrite |=> regAck && regErr && // RULE16
        regRdata == `SIOS_RST_WORD)
        else $error("write not refused");
    AST_WRITE_NO_EFFECT: assert property (sWrite |=> // RULE16
        statusQ == $past({2'b00, grossPrecLost, netPrecLost, flowDisp, 3'b000, motion,
        netMode, zeroNet, zeroGross, zeroDisp, flowOvf, grossOvf, netOvf}))
        else $error("write disturbed status");
endmodule // sios_status_bank
`default_nettype wire

// File: testbench/sios_master_model.sv
// Master model: issues register reads and writes and judges value validity.
// Assumes the bank answers with a registered one-cycle acknowledge on clk_sys.
`default_nettype none
`include "sios_consts.svh"
module sios_master_model (
    input wire logic clk_sys,
    input wire logic regAck,
    input wire logic regErr,
    input wire sios_pkg::sios_word_t regRdata,
    output logic regRd,
    output logic regWr,
    output sios_pkg::sios_idx_t regIdx,
    output sios_pkg::sios_word_t regWdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        regRd = 1'b0;
        regWr = 1'b0;
        regIdx = 8'h00;
        regWdata = 16'h0000;
    end
    task automatic xfer(input logic wr, input sios_pkg::sios_idx_t idx,
            output sios_pkg::sios_word_t data, output logic err);
        data = 'x;
        err = 'x;
        @(posedge clk_sys);
        regRd <= !wr;
        regWr <= wr;
        regIdx <= idx;
        regWdata <= 16'ha5a5;
        @(posedge clk_sys);
        regRd <= 1'b0;
        regWr <= 1'b0;
        regIdx <= ~idx;
        regWdata <= 16'h5a5a;
        for (int n = 0; n < 4; n++) begin
            #1;
            if (regAck === 1'b1) begin
                data = regRdata;
                err = regErr;
                break;
            end
            @(posedge clk_sys);
        end
    endtask
    // A value is trusted only when the error code read beside it is zero
    task automatic readValue(input sios_pkg::sios_idx_t idx,
            output sios_pkg::sios_word_t val, output logic valid);
        sios_pkg::sios_word_t errWord;
        sios_pkg::sios_word_t st;
        logic e;
        xfer(1'b0, `SIOS_IDX_SCALE_STATUS, st, e);
        xfer(1'b0, `SIOS_IDX_SCALE_ERROR, errWord, e);
        xfer(1'b0, idx, val, e);
        valid = (errWord === 16'h0000);
    endtask
endmodule // sios_master_model
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench of the scale and I/O status register bank.
// Assumes the master model makes every register access.
`default_nettype none
`include "sios_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [15:0] statFlags = 16'h0000;
    logic [7:0] errCode = 8'h00;
    sios_pkg::sios_word_t vals[4] = '{default: 16'h0000};
    sios_pkg::sios_aout_raw_t aout[4] = '{default: 17'h00000};
    logic [47:0] digInPins = 48'h0;
    sios_pkg::sios_word_t digOutState = 16'h0000;
    logic regRd, regWr, regAck, regErr;
    sios_pkg::sios_idx_t regIdx;
    sios_pkg::sios_word_t regWdata, regRdata, v;
    logic ok;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    always #10 clk_sys = ~clk_sys;
    sios_status_bank u_sios_status_bank (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
        .netOvf(statFlags[0]), .grossOvf(statFlags[1]), .flowOvf(statFlags[2]),
        .zeroDisp(statFlags[3]), .zeroGross(statFlags[4]), .zeroNet(statFlags[5]),
        .netMode(statFlags[6]), .motion(statFlags[7]), .flowDisp(statFlags[11]),
        .netPrecLost(statFlags[12]), .grossPrecLost(statFlags[13]), .errCode(errCode),
        .grossWeight(vals[0]), .netWeight(vals[1]), .flowRate(vals[2]), .inputSignal(vals[3]),
        .aoutRaw0(aout[0]), .aoutRaw1(aout[1]), .aoutRaw2(aout[2]), .aoutRaw3(aout[3]),
        .digInPins(digInPins), .digOutState(digOutState), .regRd(regRd), .regWr(regWr),
        .regIdx(regIdx), .regWdata(regWdata), .regAck(regAck), .regErr(regErr),
        .regRdata(regRdata));
    sios_master_model u_sios_master_model (.clk_sys(clk_sys), .regAck(regAck),
        .regErr(regErr), .regRdata(regRdata), .regRd(regRd), .regWr(regWr),
        .regIdx(regIdx), .regWdata(regWdata));
    task automatic chk(input sios_pkg::sios_word_t got, input sios_pkg::sios_word_t exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input sios_pkg::sios_idx_t idx, input sios_pkg::sios_word_t exp,
            input logic expErr);
        sios_pkg::sios_word_t d;
        logic e;
        u_sios_master_model.xfer(1'b0, idx, d, e);
        chk(d, exp);
        chk({15'h0000, e}, {15'h0000, expErr});
    endtask
    task automatic t_status();
        sios_pkg::sios_word_t e;
        for (int b = 0; b < 17; b++) begin
            e = (b == 16) ? 16'hffff : 16'h0001 << b;
            @(posedge clk_sys);
            statFlags <= e;
            rd(`SIOS_IDX_SCALE_STATUS, e & 16'h38ff, 1'b0);
        end
        $display("test status done");
    endtask
    task automatic t_values();
        @(posedge clk_sys);
        vals <= '{16'h1234, 16'h8567, 16'h89ab, 16'hfedc};
        for (int i = 0; i < 4; i++) begin
            u_sios_master_model.readValue(8'h02 + 8'(i), v, ok);
            chk(v, (i == 0) ? 16'h1234 : (i == 1) ? 16'h8567 : (i == 2) ? 16'h89ab : 16'hfedc);
            chk({15'h0000, ok}, 16'h0001);
        end
        rd(`SIOS_IDX_SCALE_ERROR, 16'h0000, 1'b0);
        @(posedge clk_sys);
        errCode <= 8'hff;
        u_sios_master_model.readValue(`SIOS_IDX_FLOW, v, ok);
        chk({15'h0000, ok}, 16'h0000);
        rd(`SIOS_IDX_SCALE_ERROR, 16'h00ff, 1'b0);
        $display("test values done");
    endtask
    task automatic t_aout();
        @(posedge clk_sys);
        aout <= '{17'h0000e, 17'h0000f, 17'h1ffff, 17'h00004};
        rd(8'h06, 16'h0001, 1'b0);
        rd(8'h07, 16'h0002, 1'b0);
        rd(8'h08, 16'h3333, 1'b0);
        rd(8'h09, 16'h0000, 1'b0);
        $display("test analog done");
    endtask
    task automatic t_dio();
        @(posedge clk_sys);
        digInPins <= 48'hc3a5_0f18_5a81;
        digOutState <= 16'h9c36;
        repeat (3) @(posedge clk_sys);
        rd(`SIOS_IDX_INPUT_11_28, 16'h5a81, 1'b0);
        rd(`SIOS_IDX_INPUT_31_48, 16'h0f18, 1'b0);
        rd(`SIOS_IDX_INPUT_51_68, 16'hc3a5, 1'b0);
        rd(`SIOS_IDX_OUTPUT_11_28, 16'h9c36, 1'b0);
        $display("test digital done");
    endtask
    task automatic t_write();
        @(posedge clk_sys);
        statFlags <= 16'h0041;
        for (int i = 0; i < 14; i++) begin
            u_sios_master_model.xfer(1'b1, 8'(i), v, ok);
            chk(v, 16'h0000);
            chk({15'h0000, ok}, 16'h0001);
        end
        rd(`SIOS_IDX_SCALE_STATUS, 16'h0041, 1'b0);
        rd(8'h0e, 16'h0000, 1'b1);
        $display("test write done");
    endtask
    task automatic test_done();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        t_status();
        t_values();
        t_aout();
        t_dio();
        t_write();
        test_done();
    end
endmodule // testbench
`default_nettype wire
